// [hw/cbam_regs.svh]
// constants of the cpu bus access and block move core
// assumes inclusion by the package and the core; definitions only
// What this block does
// - copy count bytes, bump pointers; zero does nothing
// - next instruction right after last byte
// - execution, halt and exception states with modes
// - active uses system clock, subactive subclock
// - interrupt pushes program counter and flags
// - every bus cycle takes two states
// - memory bus 16 bits, byte or word
// - peripheral bus 8 bits, bytes only
// - empty area: writes lost, reads all ones
// - word write to io keeps upper byte
// - word read from io fills upper half
// - bit ops are 8-bit read-modify-write
// - shared timer address: read counter, write reload
// - standard input bit writes back pin level
// - high-voltage input high turns output on
// - high-voltage output read low turns off
// - standard output bit reads data register
`ifndef CBAM_REGS_SVH
`define CBAM_REGS_SVH
`define CBAM_ROM_TOP 16'h3FFF
`define CBAM_RAM_BASE 16'hF780
`define CBAM_RAM_TOP 16'hFF7F
`define CBAM_IO_BASE 16'hFF80
`define CBAM_TMR_ADDR 16'hFFC3
`define CBAM_PORT_ADDR 16'hFFD1
`define CBAM_EMPTY_BYTE 8'hFF
`define CBAM_WORD_STEP 16'h0002
`define CBAM_BYTE_STEP 16'h0001
`define CBAM_COUNT_ONE 8'h01
`define CBAM_COUNT_ZERO 8'h00
`define CBAM_TMR_RST 8'h00
`define CBAM_PORT_RST 8'h00
`endif

// [hw/cbam_pkg.sv]
// types and shared decode of the cpu bus access core
// assumes cbam_regs.svh is on the include path
`include "cbam_regs.svh"
package cbam_pkg;
    typedef enum logic [2:0] {
        PH_IDLE = 3'h1, PH_T1 = 3'h2, PH_T2 = 3'h4
    } cbam_phase_type;
    typedef enum logic [6:0] {
        OP_ACCESS = 7'h01, OP_RMW_RD = 7'h02, OP_RMW_WR = 7'h04, OP_MV_RD = 7'h08,
        OP_MV_WR = 7'h10, OP_PUSH_PC = 7'h20, OP_PUSH_CCR = 7'h40
    } cbam_op_type;
    typedef enum logic [2:0] {
        CMD_READ = 3'h0, CMD_WRITE = 3'h1, CMD_BSET = 3'h2, CMD_BCLR = 3'h3,
        CMD_MOVE = 3'h4, CMD_IRQ = 3'h5, CMD_MODE = 3'h6
    } cbam_cmd_type;
    typedef enum logic [4:0] {
        MODE_ACTIVE = 5'h01, MODE_SUBACTIVE = 5'h02, MODE_SLEEP = 5'h04,
        MODE_STANDBY = 5'h08, MODE_WATCH = 5'h10
    } cbam_mode_type;
    typedef enum logic [2:0] {
        CPU_EXEC = 3'h1, CPU_HALT = 3'h2, CPU_EXCP = 3'h4
    } cbam_cpu_type;
    typedef enum logic [1:0] {
        AREA_MEM = 2'h0, AREA_IO = 2'h1, AREA_LOCAL = 2'h2, AREA_EMPTY = 2'h3
    } cbam_area_type;
    typedef struct packed {
        cbam_phase_type phase;
        cbam_op_type op;
        cbam_cpu_type cpu;
        cbam_mode_type mode;
        logic [15:0] addr;
        logic we;
        logic word;
        logic [15:0] wdata;
        logic [15:0] rdata;
        logic [7:0] count;
        logic [15:0] src;
        logic [15:0] dst;
        logic [15:0] sp;
        logic [15:0] base;
        logic [15:0] pc;
        logic [7:0] condition_code_reg;
        logic [2:0] bitn;
        logic setb;
        logic mem_req;
        logic per_req;
        logic done;
    } cbam_state_type;

    // address map decode, used by the sequencer and by the read data select
    function automatic cbam_area_type area_of(input logic [15:0] a);
        if (a <= `CBAM_ROM_TOP || (a >= `CBAM_RAM_BASE && a <= `CBAM_RAM_TOP)) begin
            return AREA_MEM;
        end else if (a == `CBAM_TMR_ADDR || a == `CBAM_PORT_ADDR) begin
            return AREA_LOCAL;
        end else if (a >= `CBAM_IO_BASE) begin
            return AREA_IO;
        end
        return AREA_EMPTY;
    endfunction : area_of

    // single bit set or clear inside a byte
    function automatic logic [7:0] bit_mod(input logic [7:0] b, input logic [2:0] n,
                                           input logic s);
        logic [7:0] r;
        r = b;
        r[n] = s;
        return r;
    endfunction : bit_mod
endpackage : cbam_pkg

// [hw/cbam_timer.sv]
// reloadable 8-bit timer with counter and reload on one address
// assumes writes come as one-cycle strobes from the core
`timescale 1ns/1ns
`include "cbam_regs.svh"
module cbam_timer (
    input wire logic clk_sys_i,
    input wire logic rst_i,
    input wire logic wr_i,
    input wire logic [7:0] wdata_i,
    output logic [7:0] count_o
);
    typedef struct packed {
        logic [7:0] cnt;
        logic [7:0] reload;
    } cbam_tmr_type;
    cbam_tmr_type q, d;

    // writes land in the reload value only; reads see the live count
    always_comb begin
        d = q;
        if (wr_i) begin
            d.reload = wdata_i;
        end
        d.cnt = (q.cnt == 8'hFF) ? q.reload : q.cnt + 8'h01;
    end

    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            q <= {`CBAM_TMR_RST, `CBAM_TMR_RST};
        end else begin
            q <= d;
        end
    end

    assign count_o = q.cnt;
endmodule : cbam_timer

// [hw/cbam_port.sv]
// 8-bit port whose data register shares its address with the pins
// assumes pin levels synchronous to the clock, direction and hv mask static
`timescale 1ns/1ns
`include "cbam_regs.svh"
module cbam_port (
    input wire logic clk_sys_i,
    input wire logic rst_i,
    input wire logic wr_i,
    input wire logic [7:0] wdata_i,
    input wire logic [7:0] pin_i,
    input wire logic [7:0] dir_i,
    input wire logic [7:0] hv_i,
    output logic [7:0] rdata_o,
    output logic [7:0] dr_o,
    output logic [7:0] oe_o
);
    typedef struct packed {
        logic [7:0] dr;
    } cbam_port_type;
    cbam_port_type q, d;

    // a read-modify-write stores back whatever was read
    always_comb begin
        d = q;
        if (wr_i) begin
            d.dr = wdata_i;
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            q <= `CBAM_PORT_RST;
        end else begin
            q <= d;
        end
    end

    // high-voltage bits read the pin, standard ones by direction
    assign rdata_o = (hv_i & pin_i) | (~hv_i & ((dir_i & q.dr) | (~dir_i & pin_i)));
    // high-voltage bit drives only while its data bit is 1
    assign oe_o = (hv_i & q.dr) | (~hv_i & dir_i);
    assign dr_o = q.dr;
endmodule : cbam_port

// [hw/cbam_core.sv]
// cpu bus sequencer: accesses, bit ops, block move, interrupt push
// assumes memory and peripherals answer in the second state of a cycle
`timescale 1ns/1ns
`include "cbam_regs.svh"
module cbam_core (
    input wire logic clk_sys_i,
    input wire logic rst_i,
    input wire logic cmd_valid_i,
    output logic cmd_ready_o,
    input wire logic [2:0] cmd_op_i,
    input wire cbam_pkg::cbam_mode_type cmd_mode_i,
    input wire logic [15:0] cmd_addr_i,
    input wire logic cmd_word_i,
    input wire logic [15:0] cmd_wdata_i,
    input wire logic [2:0] cmd_bit_i,
    input wire logic [7:0] cmd_count_i,
    input wire logic [15:0] cmd_src_i,
    input wire logic [15:0] cmd_dst_i,
    input wire logic [15:0] cmd_sp_i,
    input wire logic [15:0] cmd_pc_i,
    input wire logic [7:0] cmd_ccr_i,
    output logic done_o,
    output logic [15:0] rdata_o,
    output logic [7:0] count_o,
    output logic [15:0] src_o,
    output logic [15:0] dst_o,
    output logic [15:0] sp_o,
    output cbam_pkg::cbam_cpu_type cpu_state_o,
    output cbam_pkg::cbam_mode_type mode_o,
    output logic clk_sub_sel_o,
    output logic mem_req_o,
    output logic mem_we_o,
    output logic mem_word_o,
    output logic [15:0] mem_addr_o,
    output logic [15:0] mem_wdata_o,
    input wire logic [15:0] mem_rdata_i,
    output logic per_req_o,
    output logic per_we_o,
    output logic [15:0] per_addr_o,
    output logic [7:0] per_wdata_o,
    input wire logic [7:0] per_rdata_i,
    input wire logic [7:0] port_pin_i,
    input wire logic [7:0] port_dir_i,
    input wire logic [7:0] port_hv_i,
    output logic [7:0] port_dr_o,
    output logic [7:0] port_oe_o,
    output logic [7:0] timer_count_o
);
    cbam_pkg::cbam_state_type q, d;
    cbam_pkg::cbam_area_type area;
    logic [7:0] rbyte;
    logic [15:0] rword;
    logic [7:0] port_rdata;
    logic tmr_wr, port_wr;

    // start one two-state bus cycle; io gets the upper byte of a word
    function automatic cbam_pkg::cbam_state_type issue(input cbam_pkg::cbam_state_type s,
        input logic [15:0] a, input logic we, input logic word, input logic [15:0] w);
        cbam_pkg::cbam_state_type r;
        cbam_pkg::cbam_area_type ar;
        r = s;
        ar = cbam_pkg::area_of(a);
        r.phase = cbam_pkg::PH_T1;
        r.addr = a;
        r.we = we;
        r.word = word;
        if (!word) begin
            r.wdata = {w[7:0], w[7:0]};
        end else if (ar != cbam_pkg::AREA_MEM) begin
            r.wdata = {w[15:8], w[15:8]};
        end else begin
            r.wdata = w;
        end
        r.mem_req = (ar == cbam_pkg::AREA_MEM);
        r.per_req = (ar == cbam_pkg::AREA_IO);
        return r;
    endfunction : issue

    // empty area never reaches a bus: writes vanish, reads give all ones
    always_comb begin
        area = cbam_pkg::area_of(q.addr);
        unique case (area)
            cbam_pkg::AREA_MEM: rbyte = q.addr[0] ? mem_rdata_i[7:0] : mem_rdata_i[15:8];
            cbam_pkg::AREA_IO: rbyte = per_rdata_i;
            cbam_pkg::AREA_LOCAL: rbyte = (q.addr == `CBAM_TMR_ADDR) ? timer_count_o : port_rdata;
            cbam_pkg::AREA_EMPTY: rbyte = `CBAM_EMPTY_BYTE;
        endcase
        if (!q.word) begin
            rword = {8'h00, rbyte};
        end else if (area == cbam_pkg::AREA_MEM) begin
            rword = mem_rdata_i;
        end else begin
            rword = {rbyte, `CBAM_EMPTY_BYTE};
        end
    end

    // local registers are written in the first state of a cycle
    assign tmr_wr = (q.phase == cbam_pkg::PH_T1) && q.we && (q.addr == `CBAM_TMR_ADDR);
    assign port_wr = (q.phase == cbam_pkg::PH_T1) && q.we && (q.addr == `CBAM_PORT_ADDR);

    // sequencer: accept a command, run its bus cycles, pulse done
    always_comb begin
        d = q;
        d.done = 1'b0;
        d.mem_req = 1'b0;
        d.per_req = 1'b0;
        unique case (q.phase)
            cbam_pkg::PH_IDLE: begin
                if (cmd_valid_i && cmd_ready_o) begin
                    d.bitn = cmd_bit_i;
                    unique case (cmd_op_i)
                        cbam_pkg::CMD_READ: begin
                            d = issue(d, cmd_addr_i, 1'b0, cmd_word_i, cmd_wdata_i);
                            d.op = cbam_pkg::OP_ACCESS;
                        end
                        cbam_pkg::CMD_WRITE: begin
                            d = issue(d, cmd_addr_i, 1'b1, cmd_word_i, cmd_wdata_i);
                            d.op = cbam_pkg::OP_ACCESS;
                        end
                        cbam_pkg::CMD_BSET, cbam_pkg::CMD_BCLR: begin
                            d = issue(d, cmd_addr_i, 1'b0, 1'b0, cmd_wdata_i);
                            d.setb = (cmd_op_i == cbam_pkg::CMD_BSET);
                            d.op = cbam_pkg::OP_RMW_RD;
                        end
                        cbam_pkg::CMD_MOVE: begin
                            d.count = cmd_count_i;
                            d.src = cmd_src_i;
                            d.dst = cmd_dst_i;
                            if (cmd_count_i == `CBAM_COUNT_ZERO) begin
                                d.done = 1'b1;
                            end else begin
                                d = issue(d, cmd_src_i, 1'b0, 1'b0, cmd_wdata_i);
                                d.op = cbam_pkg::OP_MV_RD;
                            end
                        end
                        cbam_pkg::CMD_IRQ: begin
                            d.cpu = cbam_pkg::CPU_EXCP;
                            d.base = cmd_sp_i;
                            d.pc = cmd_pc_i;
                            d.condition_code_reg = cmd_ccr_i;
                            d.sp = cmd_sp_i - `CBAM_WORD_STEP;
                            d = issue(d, cmd_sp_i - `CBAM_WORD_STEP, 1'b1, 1'b1, cmd_pc_i);
                            d.op = cbam_pkg::OP_PUSH_PC;
                        end
                        default: begin
                            // mode change; halt modes stop all bus traffic
                            d.mode = cmd_mode_i;
                            d.cpu = (cmd_mode_i == cbam_pkg::MODE_ACTIVE ||
                                     cmd_mode_i == cbam_pkg::MODE_SUBACTIVE) ?
                                    cbam_pkg::CPU_EXEC : cbam_pkg::CPU_HALT;
                            d.done = 1'b1;
                        end
                    endcase
                end
            end
            cbam_pkg::PH_T1: d.phase = cbam_pkg::PH_T2;
            cbam_pkg::PH_T2: begin
                d.phase = cbam_pkg::PH_IDLE;
                unique case (q.op)
                    cbam_pkg::OP_ACCESS: begin
                        if (!q.we) begin
                            d.rdata = rword;
                        end
                        d.done = 1'b1;
                    end
                    cbam_pkg::OP_RMW_RD: begin
                        // whole byte goes back, other bits as they were read
                        d.rdata = {8'h00, rbyte};
                        d = issue(d, q.addr, 1'b1, 1'b0,
                                  {8'h00, cbam_pkg::bit_mod(rbyte, q.bitn, q.setb)});
                        d.op = cbam_pkg::OP_RMW_WR;
                    end
                    cbam_pkg::OP_MV_RD: begin
                        d = issue(d, q.dst, 1'b1, 1'b0, {8'h00, rbyte});
                        d.op = cbam_pkg::OP_MV_WR;
                    end
                    cbam_pkg::OP_MV_WR: begin
                        // no wrap guard: the destination stays below the top
                        d.src = q.src + `CBAM_BYTE_STEP;
                        d.dst = q.dst + `CBAM_BYTE_STEP;
                        d.count = q.count - `CBAM_COUNT_ONE;
                        if (q.count == `CBAM_COUNT_ONE) begin
                            d.done = 1'b1;
                        end else begin
                            d = issue(d, q.src + `CBAM_BYTE_STEP, 1'b0, 1'b0, q.wdata);
                            d.op = cbam_pkg::OP_MV_RD;
                        end
                    end
                    cbam_pkg::OP_PUSH_PC: begin
                        d.sp = q.sp - `CBAM_WORD_STEP;
                        d = issue(d, q.sp - `CBAM_WORD_STEP, 1'b1, 1'b1, {q.condition_code_reg, q.condition_code_reg});
                        d.op = cbam_pkg::OP_PUSH_CCR;
                    end
                    default: begin
                        // rmw write back or flag push finished
                        d.cpu = cbam_pkg::CPU_EXEC;
                        d.done = 1'b1;
                    end
                endcase
            end
            default: d.phase = cbam_pkg::PH_IDLE;
        endcase
    end

    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            q <= '0;
            q.phase <= cbam_pkg::PH_IDLE;
            q.op <= cbam_pkg::OP_ACCESS;
            q.cpu <= cbam_pkg::CPU_EXEC;
            q.mode <= cbam_pkg::MODE_ACTIVE;
        end else begin
            q <= d;
        end
    end

    // halted core takes only mode commands, to wake it
    assign cmd_ready_o = (q.phase == cbam_pkg::PH_IDLE) &&
                         (q.cpu == cbam_pkg::CPU_EXEC || cmd_op_i == cbam_pkg::CMD_MODE);
    assign clk_sub_sel_o = (q.mode == cbam_pkg::MODE_SUBACTIVE);
    assign done_o = q.done;
    assign rdata_o = q.rdata;
    assign count_o = q.count;
    assign src_o = q.src;
    assign dst_o = q.dst;
    assign sp_o = q.sp;
    assign cpu_state_o = q.cpu;
    assign mode_o = q.mode;
    assign mem_req_o = q.mem_req;
    assign mem_we_o = q.we;
    assign mem_word_o = q.word;
    assign mem_addr_o = q.addr;
    assign mem_wdata_o = q.wdata;
    assign per_req_o = q.per_req;
    assign per_we_o = q.we;
    assign per_addr_o = q.addr;
    assign per_wdata_o = q.wdata[7:0];

    cbam_timer u_timer (
        .clk_sys_i(clk_sys_i),
        .rst_i(rst_i),
        .wr_i(tmr_wr),
        .wdata_i(q.wdata[7:0]),
        .count_o(timer_count_o)
    );

    cbam_port u_port (
        .clk_sys_i(clk_sys_i),
        .rst_i(rst_i),
        .wr_i(port_wr),
        .wdata_i(q.wdata[7:0]),
        .pin_i(port_pin_i),
        .dir_i(port_dir_i),
        .hv_i(port_hv_i),
        .rdata_o(port_rdata),
        .dr_o(port_dr_o),
        .oe_o(port_oe_o)
    );

    // checks on the sequencer's own outputs
    a_bus_two_states: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        (mem_req_o || per_req_o) |=> (!mem_req_o && !per_req_o && q.phase == cbam_pkg::PH_T2))
        else $error("bus cycle not two states");
    a_move_zero_count: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        (cmd_valid_i && cmd_ready_o && cmd_op_i == cbam_pkg::CMD_MOVE && cmd_count_i == 8'h00)
        |=> (done_o && !mem_req_o && !per_req_o))
        else $error("zero count move did a transfer");
    a_move_ptr_step: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        (q.phase == cbam_pkg::PH_T2 && q.op == cbam_pkg::OP_MV_WR)
        |=> (src_o == $past(src_o) + 16'h0001 && count_o == $past(count_o) - 8'h01))
        else $error("move pointers or count wrong");
    a_move_last_done: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        (q.phase == cbam_pkg::PH_T2 && q.op == cbam_pkg::OP_MV_WR && q.count == 8'h01)
        |=> (done_o && cmd_ready_o == (q.cpu == cbam_pkg::CPU_EXEC)))
        else $error("move did not finish at last byte");
    a_irq_push_sp: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        (cmd_valid_i && cmd_ready_o && cmd_op_i == cbam_pkg::CMD_IRQ)
        |=> ##4 (done_o && sp_o == q.base - 16'h0004 && cpu_state_o == cbam_pkg::CPU_EXEC))
        else $error("interrupt push wrong");
    a_halt_no_bus: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        (cpu_state_o == cbam_pkg::CPU_HALT) |-> (!mem_req_o && !per_req_o && !cmd_ready_o
        || cmd_op_i == cbam_pkg::CMD_MODE))
        else $error("bus active while halted");
    a_empty_read_ones: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        (q.phase == cbam_pkg::PH_T2 && !q.we && q.op == cbam_pkg::OP_ACCESS &&
         area == cbam_pkg::AREA_EMPTY) |=> (done_o && rdata_o[7:0] == 8'hFF))
        else $error("empty read not all ones");
    a_io_word_read: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        (q.phase == cbam_pkg::PH_T2 && !q.we && q.word && q.op == cbam_pkg::OP_ACCESS &&
         area == cbam_pkg::AREA_IO) |=> (rdata_o == {$past(per_rdata_i), 8'hFF}))
        else $error("io word read misplaced");
    a_rmw_one_bit: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        (q.phase == cbam_pkg::PH_T1 && q.op == cbam_pkg::OP_RMW_WR)
        |-> ((q.wdata[7:0] & ~(8'h01 << q.bitn)) == (rdata_o[7:0] & ~(8'h01 << q.bitn))))
        else $error("bit op touched other bits");
    a_io_word_write: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        (cmd_valid_i && cmd_ready_o && cmd_op_i == cbam_pkg::CMD_WRITE && cmd_word_i &&
         cbam_pkg::area_of(cmd_addr_i) == cbam_pkg::AREA_IO)
        |=> (per_req_o && per_wdata_o == $past(cmd_wdata_i[15:8])))
        else $error("io word write lost upper byte");

    c_move_done: cover property (@(posedge clk_sys_i) disable iff (rst_i)
        q.phase == cbam_pkg::PH_T2 && q.op == cbam_pkg::OP_MV_WR && q.count == 8'h01);
    c_irq_done: cover property (@(posedge clk_sys_i) disable iff (rst_i)
        q.phase == cbam_pkg::PH_T2 && q.op == cbam_pkg::OP_PUSH_CCR);
    c_rmw_done: cover property (@(posedge clk_sys_i) disable iff (rst_i)
        q.phase == cbam_pkg::PH_T2 && q.op == cbam_pkg::OP_RMW_WR);
    c_halt_wake: cover property (@(posedge clk_sys_i) disable iff (rst_i)
        cpu_state_o == cbam_pkg::CPU_HALT ##[1:20] cpu_state_o == cbam_pkg::CPU_EXEC);
endmodule : cbam_core

// [test/cbam_bus_model.sv]
// behavioural on-chip memory and peripheral bus seen from the core
// assumes requests are one-cycle pulses and read data is taken in the state after
`timescale 1ns/1ns
module cbam_bus_model (
    input wire logic clk_sys_i,
    input wire logic mem_req_o,
    input wire logic mem_we_o,
    input wire logic mem_word_o,
    input wire logic [15:0] mem_addr_o,
    input wire logic [15:0] mem_wdata_o,
    output logic [15:0] mem_rdata_i,
    input wire logic per_req_o,
    input wire logic per_we_o,
    input wire logic [15:0] per_addr_o,
    input wire logic [7:0] per_wdata_o,
    output logic [7:0] per_rdata_i
);
    logic [7:0] mem [0:65535];
    logic [7:0] per [0:255];
    logic mt2 = 1'h0;
    logic pt2 = 1'h0;
    logic [15:0] ma;
    logic [7:0] pa;
    logic [15:0] junk = 16'hA5C3;
    initial begin
        foreach (per[i]) per[i] = 8'h00;
    end
    // write in the request state, read answer only in the second state
    always @(posedge clk_sys_i) begin
        junk <= junk + 16'h3B5D;
        mt2 <= mem_req_o & ~mem_we_o;
        pt2 <= per_req_o & ~per_we_o;
        ma <= mem_addr_o;
        pa <= per_addr_o[7:0];
        if (mem_req_o && mem_we_o && mem_word_o) begin
            mem[{mem_addr_o[15:1], 1'h0}] <= mem_wdata_o[15:8];
            mem[{mem_addr_o[15:1], 1'h1}] <= mem_wdata_o[7:0];
        end else if (mem_req_o && mem_we_o) begin
            mem[mem_addr_o] <= mem_addr_o[0] ? mem_wdata_o[7:0] : mem_wdata_o[15:8];
        end
        if (per_req_o && per_we_o) per[per_addr_o[7:0]] <= per_wdata_o;
    end
    // released bus shows a moving pattern, never stale data
    assign mem_rdata_i = mt2 ? {mem[{ma[15:1], 1'h0}], mem[{ma[15:1], 1'h1}]} : junk;
    assign per_rdata_i = pt2 ? per[pa] : junk[7:0];
endmodule : cbam_bus_model

// [test/cbam_core_tb.sv]
// self-checking bench for the cpu bus sequencer with a bus model
// assumes the hand-over latencies: access 3, bit op 5, push 5, move 1+4n
`timescale 1ns/1ns
module cbam_core_tb;
    logic clk_sys_i, rst_i, cmd_valid_i, cmd_ready_o, cmd_word_i, done_o, clk_sub_sel_o;
    logic mem_req_o, mem_we_o, mem_word_o, per_req_o, per_we_o;
    logic [2:0] cmd_op_i, cmd_bit_i;
    cbam_pkg::cbam_mode_type cmd_mode_i, mode_o;
    cbam_pkg::cbam_cpu_type cpu_state_o;
    logic [15:0] cmd_addr_i, cmd_wdata_i, cmd_src_i, cmd_dst_i, cmd_sp_i, cmd_pc_i, rdata_o;
    logic [15:0] src_o, dst_o, sp_o, mem_addr_o, mem_wdata_o, mem_rdata_i, per_addr_o, cyc;
    logic [7:0] cmd_count_i, cmd_ccr_i, count_o, per_wdata_o, per_rdata_i, port_pin_i;
    logic [7:0] port_dir_i, port_hv_i, port_dr_o, port_oe_o, timer_count_o, r;
    int miscompares = 0, comparisons = 0, nreq = 0, n0;
    cbam_core dut (.*);
    cbam_bus_model bus (.*);
    initial begin
        clk_sys_i = 1'h0;
        forever #10 clk_sys_i = ~clk_sys_i;
    end
    // every bus strobe seen, to prove that some accesses raise none
    always @(posedge clk_sys_i) if (mem_req_o === 1'h1 || per_req_o === 1'h1) nreq++;
    task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
        comparisons++;
        if (seen !== exp) begin
            miscompares++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk
    // one command: hold valid until taken, then count edges until done
    task automatic go(input logic [2:0] op, input logic [15:0] a, d, input logic w);
        int n;
        cmd_op_i <= op;
        cmd_addr_i <= a;
        cmd_wdata_i <= d;
        cmd_word_i <= w;
        cmd_valid_i <= 1'h1;
        n = 0;
        do begin @(posedge clk_sys_i); n++; end while (cmd_ready_o !== 1'h1 && n < 50);
        cmd_valid_i <= 1'h0;
        cyc = 16'h0000;
        do begin @(posedge clk_sys_i); cyc++; end while (done_o !== 1'h1 && cyc < 16'h0064);
        if (n == 50 || cyc == 16'h0064) miscompares++;
    endtask : go
    task automatic t_mem;
        go(3'h1, 16'hF800, 16'h1234, 1'h1);
        chk("mem write cycles", cyc, 16'h0003);
        go(3'h0, 16'hF800, 16'h0000, 1'h1);
        chk("mem word read", rdata_o, 16'h1234);
        go(3'h0, 16'hF801, 16'h0000, 1'h0);
        chk("mem byte read", rdata_o, 16'h0034);
    endtask : t_mem
    task automatic t_io;
        go(3'h1, 16'hFF90, 16'h5A5A, 1'h0);
        go(3'h0, 16'hFF90, 16'h0000, 1'h0);
        chk("io byte read", rdata_o, 16'h005A);
        chk("io cycles", cyc, 16'h0003);
        go(3'h1, 16'hFF92, 16'hC33C, 1'h1);
        go(3'h0, 16'hFF93, 16'h0000, 1'h0);
        chk("io low byte lost", rdata_o, 16'h0000);
        go(3'h0, 16'hFF92, 16'h0000, 1'h1);
        chk("io word upper", {8'h00, rdata_o[15:8]}, 16'h00C3);
    endtask : t_io
    task automatic t_empty;
        n0 = nreq;
        go(3'h1, 16'h5000, 16'hBEEF, 1'h1);
        chk("empty no strobe", 16'(nreq - n0), 16'h0000);
        go(3'h0, 16'h5000, 16'h0000, 1'h1);
        chk("empty word", rdata_o, 16'hFFFF);
        go(3'h0, 16'h5001, 16'h0000, 1'h0);
        chk("empty byte", rdata_o, 16'h00FF);
    endtask : t_empty
    // bits 0-3 high voltage, 4-7 standard with 6 and 7 outputs
    task automatic t_port;
        go(3'h1, 16'hFFD1, 16'h8282, 1'h0);
        chk("port dr", {8'h00, port_dr_o}, 16'h0082);
        port_pin_i <= 8'h51;
        cmd_bit_i <= 3'h3;
        go(3'h2, 16'hFFD1, 16'h0000, 1'h0);
        chk("bset cycles", cyc, 16'h0005);
        chk("bset read", rdata_o, 16'h0091);
        chk("bset dr", {8'h00, port_dr_o}, 16'h0099);
        chk("port oe", {8'h00, port_oe_o}, 16'h00C9);
        cmd_bit_i <= 3'h7;
        go(3'h3, 16'hFFD1, 16'h0000, 1'h0);
        chk("bclr dr", {8'h00, port_dr_o}, 16'h0011);
    endtask : t_port
    // reload takes the live count read by the bit op, with the one bit set
    task automatic t_timer;
        int n;
        cmd_bit_i <= 3'h2;
        go(3'h2, 16'hFFC3, 16'h0000, 1'h0);
        r = rdata_o[7:0] | 8'h04;
        n = 0;
        do begin @(posedge clk_sys_i); n++; end while (timer_count_o !== 8'hFF && n < 300);
        @(posedge clk_sys_i);
        chk("timer reload", {8'h00, timer_count_o}, {8'h00, r});
    endtask : t_timer
    task automatic t_move;
        cmd_count_i <= 8'h02;
        cmd_src_i <= 16'hF800;
        cmd_dst_i <= 16'hF900;
        go(3'h4, 16'h0000, 16'h0000, 1'h0);
        chk("move cycles", cyc, 16'h0009);
        chk("move src", src_o, 16'hF802);
        chk("move dst", dst_o, 16'hF902);
        chk("move count", {8'h00, count_o}, 16'h0000);
        go(3'h0, 16'hF900, 16'h0000, 1'h1);
        chk("move data", rdata_o, 16'h1234);
        cmd_count_i <= 8'h00;
        n0 = nreq;
        go(3'h4, 16'h0000, 16'h0000, 1'h0);
        chk("move zero", cyc + 16'(nreq - n0), 16'h0001);
    endtask : t_move
    task automatic t_irq;
        cmd_sp_i <= 16'hFF00;
        cmd_pc_i <= 16'hABCD;
        cmd_ccr_i <= 8'h85;
        go(3'h5, 16'h0000, 16'h0000, 1'h0);
        chk("push cycles", cyc, 16'h0005);
        chk("push sp", sp_o, 16'hFEFC);
        chk("push state", 16'(cpu_state_o), 16'h0001);
        go(3'h0, 16'hFEFE, 16'h0000, 1'h1);
        chk("pushed pc", rdata_o, 16'hABCD);
        go(3'h0, 16'hFEFC, 16'h0000, 1'h1);
        chk("pushed flags", rdata_o, 16'h8585);
    endtask : t_irq
    task automatic t_modes;
        for (int i = 0; i < 6; i++) begin
            cmd_mode_i <= cbam_pkg::cbam_mode_type'(i == 5 ? 5'h01 : 5'h01 << i);
            go(3'h6, 16'h0000, 16'h0000, 1'h0);
            chk("mode", 16'(mode_o), (i == 5) ? 16'h0001 : 16'h0001 << i);
            chk("sub clock", 16'(clk_sub_sel_o), 16'(i == 1));
            chk("cpu state", 16'(cpu_state_o), (i > 1 && i < 5) ? 16'h0002 : 16'h0001);
            if (i == 4) begin
                cmd_op_i <= 3'h0;
                cmd_valid_i <= 1'h1;
                @(posedge clk_sys_i);
                chk("halt refuses", 16'(cmd_ready_o), 16'h0000);
            end
        end
    endtask : t_modes
    task automatic tally_and_finish;
        if (miscompares == 0 && comparisons > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : tally_and_finish
    initial begin
        {rst_i, cmd_valid_i, cmd_op_i, cmd_word_i, cmd_bit_i} = {1'h1, 8'h00};
        {cmd_addr_i, cmd_wdata_i, cmd_src_i, cmd_dst_i, cmd_sp_i, cmd_pc_i} = '0;
        {cmd_count_i, cmd_ccr_i, port_pin_i} = '0;
        cmd_mode_i = cbam_pkg::MODE_ACTIVE;
        port_dir_i = 8'hC0;
        port_hv_i = 8'h0F;
        repeat (6) @(posedge clk_sys_i);
        rst_i <= 1'h0;
        @(posedge clk_sys_i);
        chk("reset mode", 16'(mode_o), 16'h0001);
        t_mem();
        t_io();
        t_empty();
        t_port();
        t_timer();
        t_move();
        t_irq();
        t_modes();
        tally_and_finish();
    end
    // cut a hang well past the run's length
    initial begin
        repeat (20000) @(posedge clk_sys_i);
        miscompares++;
        tally_and_finish();
    end
endmodule : cbam_core_tb
